// [logic/tws_pkg.sv]
/*
  Constants and types shared by the two-wire control port and its
  clock-generator register bytes. Assumes nothing of its surroundings.
*/
`default_nettype none

package tws_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] TWS_PHASE_OFS = 8'h0b;
  localparam logic [7:0] TWS_BAND_OFS = 8'h0c;
  localparam logic [7:0] TWS_PORT_OFS = 8'h0d;
  localparam logic [7:0] TWS_MAX_PTR = 8'h0e;
  localparam logic [7:0] TWS_PTR_RST = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TWS_PHASE_LSB = 3;
  localparam int TWS_BAND_LSB = 5;
  localparam int TWS_PUMP_LSB = 2;
  localparam int TWS_SWAP_WR_BIT = 4;
  localparam int TWS_SWAP_RD_BIT = 7;
  localparam int TWS_REV_LSB = 1;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [4:0] TWS_PHASE_RST = 5'h10;
  localparam logic [1:0] TWS_BAND_RST = 2'h1;
  localparam logic [2:0] TWS_PUMP_RST = 3'h1;
  localparam logic TWS_SWAP_RST = 1'b0;

  // ---------------------------------------------------------------
  // serial protocol
  // ---------------------------------------------------------------
  localparam logic [4:0] TWS_DEV_ADDR_HI = 5'h13;
  localparam logic [3:0] TWS_BITS_PER_BYTE = 4'h8;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DEV  = 7'h02,
    ST_REG  = 7'h04,
    ST_WDAT = 7'h08,
    ST_ACK  = 7'h10,
    ST_RDAT = 7'h20,
    ST_MACK = 7'h40
  } tws_state_t;

endpackage

`default_nettype wire

// [logic/tws_ctrl_port.sv]
/*
  Two-wire serial slave port with the clock-generator and output-port
  control bytes 0Bh..0Dh, plus the first-pixel port steering they drive.
  Assumes scl_in/sda_in are already synchronous to clk_sys and that the
  sda wire is resolved outside from sda_oe_n (low = pull low).
*/
`timescale 1ns/1ns
`default_nettype none

module tws_ctrl_port
  import tws_pkg::*;
#(
  parameter logic [2:0] DIE_REVISION = 3'h2 // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [1:0] bus_address_select_pins,
  input wire logic dual_port_split,
  input wire logic line_sync_lead,
  input wire logic sample_valid,
  output logic port_a_sel,
  output logic port_b_sel,
  output logic [4:0] sampling_phase_step,
  output logic [1:0] oscillator_band_select,
  output logic [2:0] charge_pump_current,
  output logic first_pixel_port_swap
);

  // -----------------------------------------------------------------
  // read decode
  // -----------------------------------------------------------------
  function automatic logic [7:0] reg_read(
    input logic [7:0] addr,
    input logic [4:0] phase,
    input logic [1:0] band,
    input logic [2:0] pump,
    input logic swap
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      TWS_PHASE_OFS: v[TWS_PHASE_LSB +: 5] = phase;
      TWS_BAND_OFS: begin
        v[TWS_BAND_LSB +: 2] = band;
        v[TWS_PUMP_LSB +: 3] = pump;
      end
      TWS_PORT_OFS: begin
        v[TWS_SWAP_RD_BIT] = swap;
        v[TWS_REV_LSB +: 3] = DIE_REVISION;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  tws_state_t state_r, after_ack_r, after_ack;
  logic scl_q_r, sda_q_r, sda_oe_n_r, sda_out_r;
  logic [3:0] cnt_r;
  logic [7:0] rx_r, tx_r, ptr_r, rd_byte;
  logic [4:0] sampling_phase_step_r;
  logic [1:0] oscillator_band_select_r;
  logic [2:0] charge_pump_current_r;
  logic first_pixel_port_swap_r, odd_sample_r, port_a_sel_r, port_b_sel_r;
  logic scl_rise, scl_fall, start_det, stop_det, byte_end;
  logic dev_hit, ack_ok, wr_en, ptr_load, ptr_inc, odd_now;

  // -----------------------------------------------------------------
  // line event detection
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    sda_out_r <= 1'b0; // open drain: only ever pulls low
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_q_r;
  assign scl_fall = ~scl_in & scl_q_r;
  assign start_det = scl_in & scl_q_r & sda_q_r & ~sda_in;
  assign stop_det = scl_in & scl_q_r & ~sda_q_r & sda_in;
  assign byte_end = scl_fall && (cnt_r == TWS_BITS_PER_BYTE);
  assign dev_hit = rx_r[7:1] == {TWS_DEV_ADDR_HI, bus_address_select_pins};
  assign rd_byte = reg_read(ptr_r, sampling_phase_step_r, oscillator_band_select_r,
                            charge_pump_current_r, first_pixel_port_swap_r);

  // -----------------------------------------------------------------
  // acknowledge decision per received byte
  // -----------------------------------------------------------------
  always_comb begin
    ack_ok = 1'b0;
    after_ack = ST_WDAT;
    unique case (state_r)
      ST_DEV: begin
        ack_ok = dev_hit;
        after_ack = rx_r[0] ? ST_RDAT : ST_REG;
      end
      ST_REG: ack_ok = (rx_r <= TWS_MAX_PTR);
      ST_WDAT: ack_ok = 1'b1;
      default: ack_ok = 1'b0;
    endcase
  end

  assign wr_en = (state_r == ST_WDAT) && byte_end;
  assign ptr_load = (state_r == ST_REG) && byte_end && ack_ok;
  assign ptr_inc = wr_en || ((state_r == ST_RDAT) && byte_end);

  // -----------------------------------------------------------------
  // serial state machine
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      cnt_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      sda_oe_n_r <= 1'b1;
    end else if (start_det) begin
      state_r <= ST_DEV;
      cnt_r <= 4'h0;
      sda_oe_n_r <= 1'b1;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      sda_oe_n_r <= 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: cnt_r <= 4'h0;
        ST_DEV, ST_REG, ST_WDAT: begin
          if (scl_rise && (cnt_r < TWS_BITS_PER_BYTE)) begin
            rx_r <= {rx_r[6:0], sda_in};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_end) begin
            cnt_r <= 4'h0;
            after_ack_r <= after_ack;
            if (ack_ok) begin
              state_r <= ST_ACK;
              sda_oe_n_r <= 1'b0;
            end else begin
              state_r <= ST_IDLE;
              sda_oe_n_r <= 1'b1;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state_r <= after_ack_r;
            cnt_r <= 4'h0;
            if (after_ack_r == ST_RDAT) begin
              tx_r <= rd_byte;
              sda_oe_n_r <= rd_byte[7];
            end else begin
              sda_oe_n_r <= 1'b1;
            end
          end
        end
        ST_RDAT: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_end) begin
            state_r <= ST_MACK;
            cnt_r <= 4'h0;
            sda_oe_n_r <= 1'b1;
          end else if (scl_fall) begin
            tx_r <= {tx_r[6:0], 1'b0};
            sda_oe_n_r <= tx_r[6];
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (sda_in) begin
              state_r <= ST_IDLE;
            end else begin
              cnt_r <= 4'h1;
            end
          end else if (scl_fall && (cnt_r == 4'h1)) begin
            state_r <= ST_RDAT;
            cnt_r <= 4'h0;
            tx_r <= rd_byte;
            sda_oe_n_r <= rd_byte[7];
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // register pointer
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ptr_r <= TWS_PTR_RST;
    end else if (ptr_load) begin
      ptr_r <= rx_r;
    end else if (ptr_inc && (ptr_r < TWS_MAX_PTR)) begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  // -----------------------------------------------------------------
  // control fields
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sampling_phase_step_r <= TWS_PHASE_RST;
      oscillator_band_select_r <= TWS_BAND_RST;
      charge_pump_current_r <= TWS_PUMP_RST;
      first_pixel_port_swap_r <= TWS_SWAP_RST;
    end else if (wr_en) begin
      unique case (ptr_r)
        TWS_PHASE_OFS: sampling_phase_step_r <= rx_r[TWS_PHASE_LSB +: 5];
        TWS_BAND_OFS: begin
          oscillator_band_select_r <= rx_r[TWS_BAND_LSB +: 2];
          charge_pump_current_r <= rx_r[TWS_PUMP_LSB +: 3];
        end
        TWS_PORT_OFS: first_pixel_port_swap_r <= rx_r[TWS_SWAP_WR_BIT];
        default: first_pixel_port_swap_r <= first_pixel_port_swap_r;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // first-pixel port steering
  // -----------------------------------------------------------------
  assign odd_now = line_sync_lead | odd_sample_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      odd_sample_r <= 1'b1;
      port_a_sel_r <= 1'b0;
      port_b_sel_r <= 1'b0;
    end else begin
      if (sample_valid) begin
        odd_sample_r <= ~odd_now;
      end else if (line_sync_lead) begin
        odd_sample_r <= 1'b1;
      end
      if (!sample_valid) begin
        port_a_sel_r <= 1'b0;
        port_b_sel_r <= 1'b0;
      end else if (!dual_port_split) begin
        port_a_sel_r <= 1'b1;
        port_b_sel_r <= 1'b0;
      end else begin
        port_a_sel_r <= odd_now ^ first_pixel_port_swap_r;
        port_b_sel_r <= ~(odd_now ^ first_pixel_port_swap_r);
      end
    end
  end

  assign sda_out = sda_out_r;
  assign sda_oe_n = sda_oe_n_r;
  assign port_a_sel = port_a_sel_r;
  assign port_b_sel = port_b_sel_r;
  assign sampling_phase_step = sampling_phase_step_r;
  assign oscillator_band_select = oscillator_band_select_r;
  assign charge_pump_current = charge_pump_current_r;
  assign first_pixel_port_swap = first_pixel_port_swap_r;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence byte_done_s(tws_state_t st);
    (state_r == st) && byte_end;
  endsequence
  property phase_wr_p;
    logic [4:0] v;
    (wr_en && ptr_r == TWS_PHASE_OFS, v = rx_r[7:3]) |=> sampling_phase_step_r == v;
  endproperty
  property band_wr_p;
    logic [7:0] v;
    (wr_en && ptr_r == TWS_BAND_OFS, v = rx_r) |=>
      oscillator_band_select_r == v[6:5] && charge_pump_current_r == v[4:2];
  endproperty

  phase_field_a: assert property (phase_wr_p) else $error("phase field not stored");
  band_field_a: assert property (band_wr_p) else $error("band or pump not stored");
  steer_first_a: assert property (sample_valid && dual_port_split && line_sync_lead |=>
    port_b_sel_r == $past(first_pixel_port_swap_r) && port_a_sel_r != port_b_sel_r)
    else $error("first sample on wrong port");
  steer_single_a: assert property (sample_valid && !dual_port_split |=>
    port_a_sel_r && !port_b_sel_r) else $error("single port mode steered to b");
  readback_port_a: assert property (ptr_r == TWS_PORT_OFS |->
    rd_byte[7] == first_pixel_port_swap_r && rd_byte[4] == 1'b0 &&
    rd_byte[3:1] == DIE_REVISION) else $error("0d readback wrong");
  addr_ack_a: assert property (byte_done_s(ST_DEV) ##0 dev_hit |=>
    (!sda_oe_n_r && state_r == ST_ACK) [*2]) else $error("own address not acknowledged");
  addr_nack_a: assert property (byte_done_s(ST_DEV) ##0 !dev_hit |=>
    sda_oe_n_r && state_r == ST_IDLE) else $error("foreign address acknowledged");
  base_range_a: assert property (byte_done_s(ST_REG) ##0 (rx_r > TWS_MAX_PTR) |=>
    sda_oe_n_r && ptr_r == $past(ptr_r)) else $error("bad base acknowledged");
  ptr_sat_a: assert property (ptr_inc && ptr_r == TWS_MAX_PTR |=> ptr_r == TWS_MAX_PTR)
    else $error("pointer passed 0e");
  tx_msb_a: assert property (state_r == ST_ACK && scl_fall &&
    after_ack_r == ST_RDAT && !start_det && !stop_det |=>
    tx_r == $past(rd_byte) && sda_oe_n_r == tx_r[7]) else $error("read byte not msb first");
  master_nack_a: assert property (state_r == ST_MACK && scl_rise && sda_in
    && !stop_det && !start_det |=> state_r == ST_IDLE && sda_oe_n_r)
    else $error("line driven after master nack");
  stop_idle_a: assert property (stop_det |=> state_r == ST_IDLE && sda_oe_n_r)
    else $error("stop not honoured");
  start_dev_a: assert property (start_det |=> state_r == ST_DEV && cnt_r == 4'h0)
    else $error("start not honoured");

endmodule

`default_nettype wire

// [bench/tws_bus_master.sv]
/*
  Behavioural two-wire bus master driving the control port.
  Assumes an external pull-up on the data wire, resolved by the bench;
  sda_low high means the master pulls the wire low.
*/
`timescale 1ns/1ns
`default_nettype none

module tws_bus_master (
  input wire logic clk_sys,
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  // ---------------------------------------------------------------
  // line idle at time zero
  // ---------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ---------------------------------------------------------------
  // bus primitives
  // ---------------------------------------------------------------
  task automatic half;
    repeat (3) @(posedge clk_sys);
  endtask

  // data moved with clock low, sampled late in clock high, just before it falls
  task automatic bit_cycle(input logic b, output logic seen);
    sda_low <= !b;
    half();
    scl <= 1'b1;
    half();
    @(negedge clk_sys);
    seen = sda_in;
    @(posedge clk_sys);
    scl <= 1'b0;
    half();
  endtask

  // also serves as repeated start from clock low
  task automatic start;
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask

  task automatic stop;
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
    bit_cycle(1'b1, s);
    ack = !s;
  endtask

  // more low withholds the acknowledge to end a read
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
    bit_cycle(!more, s);
  endtask
endmodule

`default_nettype wire

// [bench/tb.sv]
/*
  Self-checking bench for the two-wire control port and its
  clock-generator bytes. Assumes the bus master model beside it.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
  import tws_pkg::*;
  localparam logic [2:0] REV = 3'h5; // arbitrary value
  logic clk_sys, rst_n, dual_port_split, line_sync_lead, sample_valid;
  logic scl, m_low, sda_w, sda_out, sda_oe_n, port_a_sel, port_b_sel, swap;
  logic [1:0] bus_address_select_pins, band;
  logic [4:0] phase;
  logic [2:0] pump;
  int fails, n_checks;

  assign sda_w = !m_low && (sda_oe_n || sda_out);

  tws_bus_master m (.clk_sys(clk_sys), .sda_in(sda_w), .scl(scl), .sda_low(m_low));

  tws_ctrl_port #(.DIE_REVISION(REV)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .bus_address_select_pins(bus_address_select_pins),
    .dual_port_split(dual_port_split), .line_sync_lead(line_sync_lead),
    .sample_valid(sample_valid), .port_a_sel(port_a_sel), .port_b_sel(port_b_sel),
    .sampling_phase_step(phase), .oscillator_band_select(band),
    .charge_pump_current(pump), .first_pixel_port_swap(swap));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test;
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic addr(input logic rd, input logic [4:0] hi, output logic ack);
    m.start();
    m.wr_byte({hi, bus_address_select_pins, rd}, ack);
  endtask

  task automatic reg_wr(input logic [7:0] base, input logic [7:0] d[$]);
    logic a;
    addr(1'b0, 5'h13, a);
    m.wr_byte(base, a);
    chk("base ack", 8'h1, a);
    foreach (d[i]) begin
      m.wr_byte(d[i], a);
      chk("data ack", 8'h1, a);
    end
    m.stop();
  endtask

  task automatic reg_rd(input logic [7:0] base, input logic [7:0] e[$]);
    logic a;
    logic [7:0] v;
    addr(1'b0, 5'h13, a);
    m.wr_byte(base, a);
    addr(1'b1, 5'h13, a);
    chk("read addr ack", 8'h1, a);
    foreach (e[i]) begin
      m.rd_byte(i < e.size() - 1, v);
      chk("read byte", e[i], v);
    end
    chk("released", 8'h1, sda_oe_n);
    m.stop();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("phase", 8'h10, phase);
    chk("band", 8'h1, band);
    chk("pump", 8'h1, pump);
    chk("sda idle", 8'h1, sda_oe_n);
    chk("sda level", 8'h0, sda_out);
    chk("port a idle", 8'h0, port_a_sel);
    chk("port b idle", 8'h0, port_b_sel);
  endtask

  task automatic t_mid_reset;
    reg_wr(8'h0d, '{8'h10});
    chk("swap set", 8'h1, swap);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_reset();
    chk("swap reset", 8'h0, swap);
  endtask

  task automatic t_addr;
    logic a;
    for (int s = 0; s < 4; s++) begin
      bus_address_select_pins <= s[1:0];
      addr(1'b0, 5'h13, a);
      chk("own addr", 8'h1, a);
      m.stop();
    end
    addr(1'b0, 5'h12, a);
    chk("foreign addr", 8'h0, a);
    m.wr_byte(8'h0b, a);
    chk("silent after", 8'h0, a);
    m.stop();
  endtask

  task automatic t_fields;
    reg_wr(8'h0b, '{8'h08, 8'h00, 8'h10});
    chk("phase", 8'h01, phase);
    chk("swap", 8'h1, swap);
    for (int i = 0; i < 8; i++) begin
      reg_wr(8'h0c, '{{1'b0, i[1:0], i[2:0], 2'b00}});
      chk("band", {6'h0, i[1:0]}, band);
      chk("pump", {5'h0, i[2:0]}, pump);
    end
  endtask

  task automatic t_read;
    reg_wr(8'h0b, '{8'hff, 8'hff, 8'hff});
    reg_rd(8'h0b, '{8'hf8, 8'h7c, {4'h8, REV, 1'b0}, 8'h00, 8'h00});
    reg_wr(8'h0d, '{8'hef});
    reg_rd(8'h0d, '{{4'h0, REV, 1'b0}});
  endtask

  task automatic t_bad_base;
    logic a;
    addr(1'b0, 5'h13, a);
    m.wr_byte(8'h0f, a);
    chk("base above max", 8'h0, a);
    m.wr_byte(8'h00, a);
    m.stop();
    chk("phase kept", 8'h1f, phase);
  endtask

  task automatic steer(input logic dual, input logic sw);
    reg_wr(8'h0d, '{{3'h0, sw, 4'h0}});
    dual_port_split <= dual;
    line_sync_lead <= 1'b1;
    sample_valid <= 1'b1;
    @(posedge clk_sys);
    line_sync_lead <= 1'b0;
    sample_valid <= 1'b0;
    @(negedge clk_sys);
    chk("first a", !dual || !sw, port_a_sel);
    chk("first b", dual && sw, port_b_sel);
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    @(negedge clk_sys);
    chk("second a", !dual || sw, port_a_sel);
    chk("second b", dual && !sw, port_b_sel);
    @(posedge clk_sys);
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog, main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = !clk_sys;
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    dual_port_split = 1'b0;
    line_sync_lead = 1'b0;
    sample_valid = 1'b0;
    bus_address_select_pins = 2'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_reset();
    t_addr();
    t_fields();
    t_read();
    t_bad_base();
    t_mid_reset();
    for (int d = 0; d < 2; d++) begin
      steer(d[0], 1'b0);
      steer(d[0], 1'b1);
    end
    end_of_test();
  end
endmodule

`default_nettype wire
